// file: verilog/cop_packer.sv
// CAN output signal packer: AHB-Lite configured, five slots into an 8-byte frame.
`timescale 1ns/10ps
`include "cop_cfg.svh"
// What this block does
// - Slot type, Undefined after reset.
// - Slot source select, unconnected after reset.
// - Optional inversion before encoding, off at reset.
// - Byte position 1..8; continuous LSB there.
// - Discrete bit position 1..8 within byte.
// - Continuous code divides by nonzero resolution.
// - Continuous code subtracts per-slot offset.
// - Continuous value clamped between min and max.
// - Reset defaults byte1 bit1 res1 off0 max1 min0.
// - Five slots packed into one frame.
// - Frame goes to global destination address.
module cop_packer
   import cop_pkg::*;
(
   input  wire logic                        hclk,
   input  wire logic                        hresetn,
   input  wire logic                        hsel,
   input  wire logic [31:0]                 haddr,
   input  wire logic [1:0]                  htrans,
   input  wire logic                        hwrite,
   input  wire logic [2:0]                  hsize,
   input  wire logic [31:0]                 hwdata,
   input  wire logic                        hready,
   output logic      [31:0]                 hrdata_ff,
   output logic                             hreadyout_ff,
   output logic                             hresp_ff,
   input  wire logic [`COP_NSRC*32-1:0]     src_vals,
   input  wire logic                        tx_req,
   output logic      [63:0]                 tx_data_ff,
   output logic                             tx_valid_ff,
   output logic      [7:0]                  tx_dest_ff
);

   // ************************************************************
   // Helper functions
   // ************************************************************

   // Turns a stored 1..8 position into a 0..7 index.
   function automatic logic [2:0] pos_idx(input logic [3:0] p);
      pos_idx = 3'(p - 4'h1);
   endfunction

   // True when a stored position lies in 1..8.
   function automatic logic pos_ok(input logic [3:0] p);
      pos_ok = (p != 4'h0) && (p <= 4'h8);
   endfunction

   // Mask of the code bits for each slot type.
   function automatic logic [31:0] width_mask(input logic [2:0] t);
      case (t)
         COP_B1:  width_mask = 32'h0000_0001;
         COP_B2:  width_mask = 32'h0000_0003;
         COP_B4:  width_mask = 32'h0000_000F;
         COP_C1:  width_mask = 32'h0000_00FF;
         COP_C2:  width_mask = 32'h0000_FFFF;
         COP_C4:  width_mask = 32'hFFFF_FFFF;
         default: width_mask = 32'h0000_0000;
      endcase
   endfunction

   // ************************************************************
   // Storage
   // ************************************************************

   cop_word_t   cfg_ff  [`COP_SLOTS];   // Type, positions, inversion, source.
   cop_word_t   res_ff  [`COP_SLOTS];   // Resolution, Q16.16, never zero.
   cop_word_t   off_ff  [`COP_SLOTS];   // Offset, Q16.16.
   cop_word_t   max_ff  [`COP_SLOTS];   // Normalization maximum, Q16.16.
   cop_word_t   min_ff  [`COP_SLOTS];   // Normalization minimum, Q16.16.
   cop_word_t   nxt_cfg [`COP_SLOTS];   // Next configuration words.
   cop_word_t   nxt_res [`COP_SLOTS];   // Next resolutions.
   cop_word_t   nxt_off [`COP_SLOTS];   // Next offsets.
   cop_word_t   nxt_max [`COP_SLOTS];   // Next maxima.
   cop_word_t   nxt_min [`COP_SLOTS];   // Next minima.
   logic        wr_pend_ff;             // A write is in its data phase.
   logic [7:0]  waddr_ff;               // Byte address of that write.
   logic        nxt_wr_pend;            // Next write-pending flag.
   logic [7:0]  nxt_waddr;              // Next write address.
   logic [31:0] nxt_rdata;              // Next read data.
   logic [63:0] nxt_txd;                // Next frame data.
   logic [63:0] pack_w;                 // Frame data as packed now.
   logic [63:0] mask_w  [`COP_SLOTS];   // Bits each slot owns.
   logic [63:0] dat_w   [`COP_SLOTS];   // Each slot's bits, already masked.
   logic        acc_w;                  // Address phase accepted.
   logic [2:0]  aslot_w;                // Slot addressed in address phase.
   logic [2:0]  aofs_w;                 // Word within that slot.
   logic [2:0]  wslot_w;                // Slot addressed by the pending write.
   logic [2:0]  wofs_w;                 // Word within that slot.

   assign acc_w   = hsel && htrans[1] && hready;
   assign aslot_w = haddr[7:5];
   assign aofs_w  = haddr[4:2];
   assign wslot_w = waddr_ff[7:5];
   assign wofs_w  = waddr_ff[4:2];

   // ************************************************************
   // Per-slot encoder
   // ************************************************************

   genvar g;
   generate
      for (g = 0; g < `COP_SLOTS; g++)
      begin : g_slot
         // Selects, inverts, normalizes and encodes one slot.
         always_comb
         begin
            logic [2:0]         t;
            logic [4:0]         s;
            logic signed [31:0] v;
            logic signed [33:0] num;
            logic signed [33:0] q;
            logic [31:0]        code;
            logic [31:0]        lim;
            logic [5:0]         sh;
            logic               disc;
            logic               live;
            t    = cfg_ff[g][`COP_F_TYPE];
            s    = cfg_ff[g][`COP_F_SRC];
            v    = 32'sh0000_0000;
            num  = 34'sh0_0000_0000;
            q    = 34'sh0_0000_0000;
            code = 32'h0000_0000;
            lim  = 32'h0000_0000;
            sh   = 6'h00;
            disc = (t == COP_B1) || (t == COP_B2) || (t == COP_B4);
            // Unconnected sources and unknown types own no bits.
            live = (s != 5'h00) && (s <= 5'(`COP_NSRC)) && (t != COP_UNDEF) && (t <= COP_C4);
            if (live)
               v = src_vals[32*(s-5'h01) +: 32];
            if (disc)
            begin
               // Inversion mirrors the value about one half.
               if (cfg_ff[g][`COP_F_INV])
                  v = $signed(`COP_ONE) - v;
               code = (v >= $signed(`COP_HALF)) ? 32'h0000_0001 : 32'h0000_0000;
            end
            else
            begin
               // Clamp into the normalization range first.
               if (v > $signed(max_ff[g]))
                  v = $signed(max_ff[g]);
               if (v < $signed(min_ff[g]))
                  v = $signed(min_ff[g]);
               // Inversion mirrors the value inside that range.
               if (cfg_ff[g][`COP_F_INV])
                  v = 32'($signed(max_ff[g]) + $signed(min_ff[g]) - v);
               num = 34'(v) - 34'($signed(off_ff[g]));
               q   = num / 34'($signed(res_ff[g]));
               case (t)
                  COP_C1:  lim = `COP_LIM_C1;
                  COP_C2:  lim = `COP_LIM_C2;
                  default: lim = `COP_LIM_C4;
               endcase
               // Codes outside valid data saturate at its edges.
               if (q < 34'sh0_0000_0000)
                  code = 32'h0000_0000;
               else if (q > $signed({2'b00, lim}))
                  code = lim;
               else
                  code = q[31:0];
            end
            // Continuous codes start at bit 0 of the byte; discrete at their bit.
            sh = {pos_idx(cfg_ff[g][`COP_F_BYTE]), 3'h0};
            if (disc)
               sh = sh + {3'h0, pos_idx(cfg_ff[g][`COP_F_BIT])};
            mask_w[g] = live ? ({32'h0000_0000, width_mask(t)} << sh) : 64'h0000_0000_0000_0000;
            // A discrete field never spills into the next byte.
            if (disc)
               mask_w[g] = mask_w[g] & (64'h0000_0000_0000_00FF << {pos_idx(cfg_ff[g][`COP_F_BYTE]), 3'h0});
            dat_w[g] = ({32'h0000_0000, code} << sh) & mask_w[g];
         end
      end
   endgenerate

   // ************************************************************
   // Frame merge and output
   // ************************************************************

   // Later slots overwrite earlier ones; owned bits only.
   always_comb
   begin
      pack_w = 64'h0000_0000_0000_0000;
      for (int i = 0; i < `COP_SLOTS; i++)
         pack_w = (pack_w & ~mask_w[i]) | dat_w[i];
      nxt_txd = tx_req ? pack_w : tx_data_ff;
   end

   // Registers the frame on each request.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         tx_data_ff  <= 64'h0000_0000_0000_0000;
         tx_valid_ff <= 1'b0;
         tx_dest_ff  <= `COP_DEST_GLOB;
      end
      else
      begin
         tx_data_ff  <= nxt_txd;
         tx_valid_ff <= tx_req;
         tx_dest_ff  <= `COP_DEST_GLOB;
      end
   end

   // ************************************************************
   // AHB-Lite slave
   // ************************************************************

   // Computes register writes, read data and the write pipeline.
   always_comb
   begin
      nxt_cfg     = cfg_ff;
      nxt_res     = res_ff;
      nxt_off     = off_ff;
      nxt_max     = max_ff;
      nxt_min     = min_ff;
      nxt_wr_pend = acc_w && hwrite && (haddr[31:8] == 24'h00_0000);
      nxt_waddr   = haddr[7:0];
      nxt_rdata   = 32'h0000_0000;
      // Writes land in the data phase; out-of-range type, byte and bit fields are refused.
      if (wr_pend_ff && (wslot_w < 3'(`COP_SLOTS)))
      begin
         case (wofs_w)
            `COP_OFS_CFG:
               if ((hwdata[`COP_F_TYPE] <= COP_C4) && pos_ok(hwdata[`COP_F_BYTE]) && pos_ok(hwdata[`COP_F_BIT]))
                  nxt_cfg[wslot_w] = hwdata & `COP_CFG_MASK;
            `COP_OFS_RES:
               if (hwdata != 32'h0000_0000)
                  nxt_res[wslot_w] = hwdata;
            `COP_OFS_OFF: nxt_off[wslot_w] = hwdata;
            `COP_OFS_MAX: nxt_max[wslot_w] = hwdata;
            `COP_OFS_MIN: nxt_min[wslot_w] = hwdata;
            default:      nxt_res[wslot_w] = res_ff[wslot_w];
         endcase
      end
      // Reads are looked up in the address phase.
      if (acc_w && !hwrite && (haddr[31:8] == 24'h00_0000))
      begin
         if (aslot_w < 3'(`COP_SLOTS))
         begin
            case (aofs_w)
               `COP_OFS_CFG: nxt_rdata = cfg_ff[aslot_w];
               `COP_OFS_RES: nxt_rdata = res_ff[aslot_w];
               `COP_OFS_OFF: nxt_rdata = off_ff[aslot_w];
               `COP_OFS_MAX: nxt_rdata = max_ff[aslot_w];
               `COP_OFS_MIN: nxt_rdata = min_ff[aslot_w];
               default:      nxt_rdata = 32'h0000_0000;
            endcase
         end
         else
         begin
            case (haddr[7:0])
               `COP_ADR_DLO:  nxt_rdata = pack_w[31:0];
               `COP_ADR_DHI:  nxt_rdata = pack_w[63:32];
               `COP_ADR_STAT: nxt_rdata = {24'h00_0000, tx_dest_ff};
               default:       nxt_rdata = 32'h0000_0000;
            endcase
         end
      end
   end

   // Registers the slave state and configuration.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         for (int i = 0; i < `COP_SLOTS; i++)
         begin
            cfg_ff[i] <= {11'h000, 5'h00, 3'h0, 1'b0, `COP_RST_POS, `COP_RST_POS, 1'b0, 3'(COP_UNDEF)};
            res_ff[i] <= `COP_RST_RES;
            off_ff[i] <= `COP_RST_OFF;
            max_ff[i] <= `COP_RST_MAX;
            min_ff[i] <= `COP_RST_MIN;
         end
         wr_pend_ff   <= 1'b0;
         waddr_ff     <= 8'h00;
         hrdata_ff    <= 32'h0000_0000;
         hreadyout_ff <= 1'b1;
         hresp_ff     <= 1'b0;
      end
      else
      begin
         cfg_ff       <= nxt_cfg;
         res_ff       <= nxt_res;
         off_ff       <= nxt_off;
         max_ff       <= nxt_max;
         min_ff       <= nxt_min;
         wr_pend_ff   <= nxt_wr_pend;
         waddr_ff     <= nxt_waddr;
         hrdata_ff    <= nxt_rdata;
         hreadyout_ff <= 1'b1;
         hresp_ff     <= 1'b0;
      end
   end

   // ************************************************************
   // Assertions
   // ************************************************************

   logic live0;  // Slot 0 has a connected source.
   assign live0 = (cfg_ff[0][`COP_F_SRC] != 5'h00) && (cfg_ff[0][`COP_F_SRC] <= 5'(`COP_NSRC));

   a_type_legal: assert property (@(posedge hclk) disable iff (!hresetn)
      cfg_ff[0][`COP_F_TYPE] <= COP_C4) else $error("slot type out of range");
   a_unconn_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
      !live0 |-> mask_w[0] == 64'h0000_0000_0000_0000) else $error("unconnected slot owns bits");
   a_inv_bit: assert property (@(posedge hclk) disable iff (!hresetn)
      live0 && cfg_ff[0][`COP_F_TYPE] == COP_B1 && cfg_ff[0][`COP_F_INV] |->
      dat_w[0] != 64'h0000_0000_0000_0000 == ($signed(src_vals[32*(cfg_ff[0][`COP_F_SRC]-5'h01) +: 32])
      <= $signed(`COP_HALF))) else $error("inverted bit wrong");
   a_half_bit: assert property (@(posedge hclk) disable iff (!hresetn)
      live0 && cfg_ff[0][`COP_F_TYPE] == COP_B1 && !cfg_ff[0][`COP_F_INV] |->
      dat_w[0] != 64'h0000_0000_0000_0000 == ($signed(src_vals[32*(cfg_ff[0][`COP_F_SRC]-5'h01) +: 32])
      >= $signed(`COP_HALF))) else $error("one-bit threshold wrong");
   a_cont_place: assert property (@(posedge hclk) disable iff (!hresetn)
      cfg_ff[1][`COP_F_SRC] != 5'h00 && cfg_ff[1][`COP_F_SRC] <= 5'(`COP_NSRC) && cfg_ff[1][`COP_F_TYPE] == COP_C2 |->
      mask_w[1] == (64'h0000_0000_0000_FFFF << {pos_idx(cfg_ff[1][`COP_F_BYTE]), 3'h0}))
      else $error("continuous placement wrong");
   a_disc_place: assert property (@(posedge hclk) disable iff (!hresetn)
      live0 && cfg_ff[0][`COP_F_TYPE] == COP_B1 |->
      mask_w[0] == (64'h0000_0000_0000_0001 << {pos_idx(cfg_ff[0][`COP_F_BYTE]), pos_idx(cfg_ff[0][`COP_F_BIT])}))
      else $error("discrete placement wrong");
   a_res_nonzero: assert property (@(posedge hclk) disable iff (!hresetn)
      res_ff[1] != 32'h0000_0000) else $error("zero resolution stored");
   a_frame_load: assert property (@(posedge hclk) disable iff (!hresetn)
      tx_req |=> tx_valid_ff && tx_data_ff == $past(pack_w)) else $error("frame not captured");
   a_dest_glob: assert property (@(posedge hclk) disable iff (!hresetn)
      tx_valid_ff |-> tx_dest_ff == `COP_DEST_GLOB) else $error("destination not global");

endmodule // cop_packer

// file: verilog/cop_cfg.svh
// Constants for the CAN output signal packer: offsets, fields, reset values, limits.
`ifndef COP_CFG_SVH
`define COP_CFG_SVH
// Slot count, source count and source select width.
`define COP_SLOTS      5
`define COP_NSRC       16
`define COP_SRCW       5
// Per-slot register block: slot base is slot index times stride.
`define COP_SLOT_STR   8'h20
`define COP_OFS_CFG    3'h0
`define COP_OFS_RES    3'h1
`define COP_OFS_OFF    3'h2
`define COP_OFS_MAX    3'h3
`define COP_OFS_MIN    3'h4
// Frame data and status words after the slot blocks.
`define COP_ADR_DLO    8'hA0
`define COP_ADR_DHI    8'hA4
`define COP_ADR_STAT   8'hA8
// Fields of the slot configuration word.
`define COP_F_TYPE     2:0
`define COP_F_BYTE     7:4
`define COP_F_BIT      11:8
`define COP_F_INV      12
`define COP_F_SRC      20:16
// Bits of the slot configuration word that hold a field; the rest read 0.
`define COP_CFG_MASK   32'h001F_1FF7
// Reset values, Q16.16 where a number is in signal units.
`define COP_RST_POS    4'h1
`define COP_RST_RES    32'h0001_0000
`define COP_RST_OFF    32'h0000_0000
`define COP_RST_MAX    32'h0001_0000
`define COP_RST_MIN    32'h0000_0000
`define COP_ONE        32'h0001_0000
`define COP_HALF       32'h0000_8000
// Largest code of the valid data range of each continuous width.
`define COP_LIM_C1     32'h0000_00FA
`define COP_LIM_C2     32'h0000_FAFF
`define COP_LIM_C4     32'hFAFF_FFFF
// Global destination address of the frame.
`define COP_DEST_GLOB  8'hFF
`endif

// file: verilog/cop_pkg.sv
// Types shared by the CAN output signal packer.
package cop_pkg;
   // Signal type of one slot; codes 7 and up are not accepted.
   typedef enum logic [2:0]
   {
      COP_UNDEF = 3'h0,
      COP_B1    = 3'h1,
      COP_B2    = 3'h2,
      COP_B4    = 3'h3,
      COP_C1    = 3'h4,
      COP_C2    = 3'h5,
      COP_C4    = 3'h6
   } cop_type_e;
   // One word of register storage.
   typedef logic [31:0] cop_word_t;
endpackage

// file: verif/cop_can_node.sv
// Receiving CAN node model that captures every frame the packer hands over.
`timescale 1ns/10ps
module cop_can_node
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic [63:0] tx_data,
   input  wire logic        tx_valid,
   input  wire logic [7:0]  tx_dest,
   output logic      [63:0] frame_ff,
   output logic      [7:0]  dest_ff,
   output logic      [7:0]  count_ff
);
   // The node keeps the last frame, its destination and a frame count.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         frame_ff <= 64'h0000_0000_0000_0000;
         dest_ff  <= 8'h00;
         count_ff <= 8'h00;
      end
      else if (tx_valid)
      begin
         frame_ff <= tx_data;
         dest_ff  <= tx_dest;
         count_ff <= count_ff + 8'h01;
      end
   end
endmodule // cop_can_node

// file: verif/test_cop_packer.sv
// Self-checking bench for the CAN output signal packer.
`timescale 1ns/10ps
`include "cop_cfg.svh"
module test_cop_packer;
   // ****************
   // Signals
   // ****************
   logic                    hclk = 1'b0;
   logic                    hresetn = 1'b0;
   logic                    hsel = 1'b0;
   logic [31:0]             haddr = 32'h0000_0000;
   logic [1:0]              htrans = 2'h0;
   logic                    hwrite = 1'b0;
   logic [2:0]              hsize = 3'h2;
   logic [31:0]             hwdata = 32'h0000_0000;
   logic [`COP_NSRC*32-1:0] src_vals = '0;
   logic                    tx_req = 1'b0;
   wire  [31:0]             hrdata_ff;
   wire                     hreadyout_ff;
   wire                     hresp_ff;
   wire  [63:0]             tx_data_ff;
   wire                     tx_valid_ff;
   wire  [7:0]              tx_dest_ff;
   wire  [63:0]             frame_ff;
   wire  [7:0]              dest_ff;
   wire  [7:0]              count_ff;
   int                      bad_count = 0;
   int                      check_count = 0;
   int                      cyc = 0;

   // Clock of 20 ns period.
   always #10 hclk = ~hclk;

   cop_packer cop_packer_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout_ff), .hrdata_ff(hrdata_ff),
      .hreadyout_ff(hreadyout_ff), .hresp_ff(hresp_ff), .src_vals(src_vals), .tx_req(tx_req),
      .tx_data_ff(tx_data_ff), .tx_valid_ff(tx_valid_ff), .tx_dest_ff(tx_dest_ff));
   cop_can_node cop_can_node_i (.hclk(hclk), .hresetn(hresetn), .tx_data(tx_data_ff), .tx_valid(tx_valid_ff),
      .tx_dest(tx_dest_ff), .frame_ff(frame_ff), .dest_ff(dest_ff), .count_ff(count_ff));

   // ****************
   // Shared tasks
   // ****************
   // Prints the counts and the verdict, then stops.
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Compares a seen value with the expected one.
   task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One AHB single transfer after an idle cycle; read data taken at the edge ending the data phase.
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= a;
      hwrite <= wr;
      htrans <= 2'h2;
      @(posedge hclk);
      while (hreadyout_ff !== 1'b1) @(posedge hclk);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout_ff !== 1'b1) @(posedge hclk);
      q = hrdata_ff;
      check("hresp", hresp_ff, 64'h0);
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [31:0] a, output logic [31:0] q);
      bus(1'b0, a, 32'h0000_0000, q);
   endtask

   // Sets logical source n, counted from 1.
   task automatic src(input int n, input logic [31:0] v);
      src_vals[32*n-32 +: 32] <= v;
   endtask

   // Requests one frame and checks the pulse, the data and what the node received.
   task automatic frame(input string name, input logic [63:0] exp);
      @(posedge hclk);
      tx_req <= 1'b1;
      @(posedge hclk);
      tx_req <= 1'b0;
      #1;
      check("tx_valid", tx_valid_ff, 64'h1);
      check(name, tx_data_ff, exp);
      check("tx_dest", tx_dest_ff, `COP_DEST_GLOB);
      @(posedge hclk);
      #1;
      check("tx_valid_end", tx_valid_ff, 64'h0);
      check("node_frame", frame_ff, exp);
      check("node_dest", dest_ff, `COP_DEST_GLOB);
   endtask

   // ****************
   // Scenarios
   // ****************
   // Reset values of the slot words, two unmapped reads and an empty frame.
   task automatic test_reset;
      logic [31:0] q;
      logic [31:0] adr [6] = '{32'h0000_0084, 32'h0000_0088, 32'h0000_008C, 32'h0000_0090,
                               32'h0000_00FC, 32'h0001_0000};
      logic [31:0] exp [6] = '{32'h0001_0000, 32'h0000_0000, 32'h0001_0000, 32'h0000_0000,
                               32'h0000_0000, 32'h0000_0000};
      rd(32'h0000_0000, q);
      check("cfg_slot1", q, 64'h0000_0110);
      rd(32'h0000_0080, q);
      check("cfg_slot5", q, 64'h0000_0110);
      for (int i = 0; i < 6; i++)
      begin
         rd(adr[i], q);
         check("reset_word", q, exp[i]);
      end
      src(1, 32'h0001_0000);
      frame("empty_frame", 64'h0);
   endtask

   // One-bit discrete at byte 2 bit 3: threshold, inversion, unconnected source.
   task automatic test_discrete;
      src(1, 32'h0000_7FFF);
      wr(32'h0000_0000, 32'h0001_0321);
      frame("b1_below_half", 64'h0);
      src(1, 32'h0000_8000);
      frame("b1_half", 64'h0000_0000_0000_0400);
      wr(32'h0000_0000, 32'h0001_1321);
      src(1, 32'h0001_0000);
      frame("b1_inv_one", 64'h0);
      src(1, 32'h0000_0000);
      frame("b1_inv_zero", 64'h0000_0000_0000_0400);
      wr(32'h0000_0000, 32'h0000_1321);
      frame("no_source", 64'h0);
   endtask

   // Two-byte continuous at byte 3: resolution, offset, clamp, refused writes.
   task automatic test_continuous;
      logic [31:0] q;
      wr(32'h0000_0024, 32'h0000_0100);
      wr(32'h0000_002C, 32'h0064_0000);
      wr(32'h0000_0020, 32'h0002_0135);
      src(2, 32'h0001_2000);
      frame("c2_code", 64'h0000_0000_0120_0000);
      wr(32'h0000_0028, 32'h0000_8000);
      frame("c2_offset", 64'h0000_0000_00A0_0000);
      wr(32'h0000_0028, 32'h0000_0000);
      src(2, 32'h00C8_0000);
      frame("c2_clamp", 64'h0000_0000_6400_0000);
      wr(32'h0000_0024, 32'h0000_0000);
      rd(32'h0000_0024, q);
      check("res_zero_kept", q, 64'h0000_0100);
      wr(32'h0000_0020, 32'h0002_0137);
      rd(32'h0000_0020, q);
      check("bad_type_kept", q, 64'h0002_0135);
      wr(32'h0000_0020, 32'h0002_0195);
      rd(32'h0000_0020, q);
      check("bad_byte_kept", q, 64'h0002_0135);
   endtask

   // Four connected slots at once with slot 1 unconnected, including byte 8 and a four-byte field.
   task automatic test_five;
      logic [31:0] q;
      src(3, 32'h0003_0000);
      src(4, 32'h0001_0000);
      src(5, 32'h0001_0000);
      wr(32'h0000_0040, 32'h0003_0156);
      wr(32'h0000_0060, 32'h0004_0113);
      wr(32'h0000_0080, 32'h0005_0782);
      frame("five_slots", 64'h4000_0001_6400_0001);
      rd(32'h0000_00A0, q);
      check("live_low", q, 64'h6400_0001);
      rd(32'h0000_00A4, q);
      check("live_high", q, 64'h4000_0001);
      rd(32'h0000_00A8, q);
      check("status_dest", q, `COP_DEST_GLOB);
   endtask

   // A second reset in mid-run brings back the slot defaults and an empty frame.
   task automatic test_rerun;
      logic [31:0] q;
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      rd(32'h0000_0040, q);
      check("cfg_slot3_again", q, 64'h0000_0110);
      rd(32'h0000_0024, q);
      check("res_slot2_again", q, 64'h0001_0000);
      frame("empty_again", 64'h0);
      check("node_count_again", count_ff, 64'h01);
   endtask

   // ****************
   // Main sequence and timeout
   // ****************
   initial
   begin
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      test_reset;
      test_discrete;
      test_continuous;
      test_five;
      check("node_count", count_ff, 64'h0A);
      test_rerun;
      end_of_test;
   end

   // Cuts a hang short.
   always @(posedge hclk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         bad_count++;
         end_of_test;
      end
   end
endmodule // test_cop_packer
